// >>> hw/misc_csr_pkg.sv
package misc_csr_pkg;

	// Register byte offsets on the host bus
	localparam logic [7:0] OFS_TIMER_CONFIG = 8'h8c;
	localparam logic [7:0] OFS_TIMER_CURRENT_VALUE = 8'h90;
	localparam logic [7:0] OFS_HOST_WORD_ORDER = 8'h98;
	localparam logic [7:0] OFS_FREE_RUNNING_TICK_COUNT = 8'h9c;
	localparam logic [7:0] OFS_LOST_FRAME_COUNTER = 8'ha0;
	localparam logic [7:0] OFS_MAC_INDIRECT_COMMAND = 8'ha4;
	localparam logic [7:0] OFS_MAC_INDIRECT_VALUE = 8'ha8;

	// Field positions within 32-bit registers
	localparam int RUN_BIT = 29;
	localparam int BUSY_BIT = 31;
	localparam int READ_NOT_WRITE_BIT = 30;
	localparam int HALF_WIDTH = 16;

	// Reset values
	localparam logic [15:0] PRELOAD_RESET = 16'hffff;
	localparam logic [15:0] COUNT_RESET = 16'hffff;
	localparam logic [31:0] WORD_ORDER_RESET = 32'h0000_0000;
	localparam logic [31:0] TICK_COUNT_RESET = 32'h0000_0000;
	localparam logic [31:0] DROP_RESET = 32'h0000_0000;
	localparam logic [31:0] MAC_VALUE_RESET = 32'h0000_0000;
	localparam logic [7:0] MAC_ADDR_RESET = 8'h00;

	// Special values
	localparam logic [31:0] WORD_ORDER_SWAPPED = 32'hffff_ffff;
	localparam logic [31:0] DROP_BELOW_MID = 32'h7fff_ffff;
	localparam logic [31:0] DROP_MID = 32'h8000_0000;

	// Rates: 10000 kHz system clock, 25000 kHz tick reference
	localparam logic [15:0] CLK_FREQ_KHZ = 16'h2710;
	localparam logic [15:0] TICK_FREQ_KHZ = 16'h61a8;
	localparam int CLK_PERIOD_NS = 100;
	localparam int TICK_CLEAR_TIME_NS = 160;
	localparam int TICK_CLEAR_CYCLES =
		(TICK_CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_TICK_CYCLES_DEFAULT = 1000;

	typedef struct packed {
		logic [7:0] addr;
		logic rd;
		logic wr;
		logic [15:0] wdata;
	} host_bus_s;

	typedef struct packed {
		logic req;
		logic read_not_write;
		logic [7:0] addr;
		logic [31:0] wdata;
	} mac_req_s;

	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_LOW = 2'b01,
		TX_HIGH = 2'b10
	} tx_phase_e;

endpackage

// >>> hw/net_half_order.sv
`timescale 1ns/100ps
module net_half_order
	import misc_csr_pkg::*;
(
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire logic [31:0] tx_word_in,
	input wire logic tx_word_valid_in,
	output logic tx_ready_out,
	output logic [15:0] net_tx_half_out,
	output logic net_tx_valid_out,
	input wire logic [15:0] net_rx_half_in,
	input wire logic net_rx_valid_in,
	output logic [31:0] rx_word_out,
	output logic rx_word_valid_out
);

	typedef struct packed {
		tx_phase_e phase;
		logic tx_ready;
		logic [15:0] tx_high;
		logic [15:0] tx_half;
		logic tx_valid;
		logic rx_have_low;
		logic [15:0] rx_low;
		logic [31:0] rx_word;
		logic rx_valid;
	} order_state_s;

	localparam order_state_s ORDER_RESET = '{
		phase: TX_IDLE,
		tx_ready: 1'b1,
		default: '0
	};

	order_state_s s;
	order_state_s n;

	always_comb begin
		n = s;
		n.tx_valid = 1'b0;
		n.rx_valid = 1'b0;
		unique case (s.phase)
			TX_IDLE: begin
				if (tx_word_valid_in) begin
					n.tx_half = tx_word_in[15:0]; // RULE9
					n.tx_high = tx_word_in[31:16];
					n.tx_valid = 1'b1;
					n.phase = TX_LOW;
				end
			end
			TX_LOW: begin
				n.tx_half = s.tx_high; // RULE9
				n.tx_valid = 1'b1;
				n.phase = TX_HIGH;
			end
			TX_HIGH: begin
				n.phase = TX_IDLE;
			end
			default: begin
				n.phase = TX_IDLE;
			end
		endcase
		// Registered copy so the ready port leaves a flop directly
		n.tx_ready = (n.phase == TX_IDLE);
		if (net_rx_valid_in) begin
			if (s.rx_have_low) begin
				n.rx_word = {net_rx_half_in, s.rx_low}; // RULE9
				n.rx_valid = 1'b1;
				n.rx_have_low = 1'b0;
			end else begin
				n.rx_low = net_rx_half_in;
				n.rx_have_low = 1'b1;
			end
		end
	end

	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s <= ORDER_RESET;
		end else begin
			s <= n;
		end
	end

	assign tx_ready_out = s.tx_ready;
	assign net_tx_half_out = s.tx_half;
	assign net_tx_valid_out = s.tx_valid;
	assign rx_word_out = s.rx_word;
	assign rx_word_valid_out = s.rx_valid;

	chk_tx_low_first: assert property (@(posedge clock_in) // RULE9
		disable iff (!rst_n_in)
		(tx_ready_out && tx_word_valid_in) |=>
		(net_tx_valid_out && net_tx_half_out == $past(tx_word_in[15:0]))
		##1 (net_tx_valid_out && net_tx_half_out == $past(tx_word_in[31:16], 2)))
		else $error("transmit halves not sent low word first");

endmodule

// >>> hw/misc_system_csr_block.sv
//Contract
// RULE1: Run bit starts timer, zero halts it
// RULE2: Run falling edge presets preload to ones
// RULE3: Timer starts counting from preload value
// RULE4: Timer interrupt at each completed interval
// RULE5: Live timer count readable, resets all ones
// RULE6: Count down per tick, reload at zero
// RULE7: Normal order: A1 set selects upper half
// RULE8: Word order all ones: A1 set selects lower
// RULE9: Network side always moves lower word first
// RULE10: 32-bit counter, reset zero, 25MHz increments
// RULE11: First half read latches whole count
// RULE12: Counter clear may lag reset 160 ns
// RULE13: Counter runs in every power state
// RULE14: Dropped frame increments the lost counter
// RULE15: Host read clears the lost counter
// RULE16: Interrupt when lost counter crosses midpoint
// RULE17: Busy write starts indirect MAC access
// RULE18: Busy holds until done, then self-clears
// RULE19: Host leaves command, value alone while busy
// RULE20: Read-not-write bit picks read or write
// RULE21: Eight-bit field addresses the MAC register
// RULE22: Value register carries indirect write/read data
`timescale 1ns/100ps
module misc_system_csr_block
	import misc_csr_pkg::*;
#(
	parameter int TIMER_TICK_CYCLES = TIMER_TICK_CYCLES_DEFAULT
) (
	input wire logic clock_in,
	input wire logic rst_n_in,
	input wire host_bus_s host_in,
	output logic [15:0] host_rdata_out,
	output logic host_rvalid_out,
	output logic word_order_swapped_out,
	output logic timer_irq_out,
	input wire logic frame_dropped_in,
	output logic drop_half_irq_out,
	output mac_req_s mac_out,
	input wire logic mac_ack_in,
	input wire logic [31:0] mac_rdata_in,
	input wire logic [31:0] tx_word_in,
	input wire logic tx_word_valid_in,
	output logic tx_ready_out,
	output logic [15:0] net_tx_half_out,
	output logic net_tx_valid_out,
	input wire logic [15:0] net_rx_half_in,
	input wire logic net_rx_valid_in,
	output logic [31:0] rx_word_out,
	output logic rx_word_valid_out
);

	localparam logic [15:0] TICK_LAST = 16'(TIMER_TICK_CYCLES - 1);

	typedef struct packed {
		logic run;
		logic [15:0] preload;
		logic [15:0] count;
		logic [15:0] tick_div;
		logic timer_irq;
		logic [31:0] word_order;
		logic swap;
		logic [15:0] phase;
		logic [31:0] tick_count;
		logic tick_held;
		logic [31:0] tick_snap;
		logic [31:0] drop;
		logic drop_held;
		logic [31:0] drop_snap;
		logic drop_irq;
		logic busy;
		logic read_not_write;
		logic [7:0] mac_addr;
		logic [31:0] mac_value;
		logic [15:0] rdata;
		logic rvalid;
	} csr_state_s;

	localparam csr_state_s CSR_RESET = '{
		preload: PRELOAD_RESET,
		count: COUNT_RESET,
		word_order: WORD_ORDER_RESET,
		tick_count: TICK_COUNT_RESET,
		drop: DROP_RESET,
		mac_addr: MAC_ADDR_RESET,
		mac_value: MAC_VALUE_RESET,
		default: '0
	};

	csr_state_s s;
	csr_state_s n;

	logic sel_tcfg;
	logic sel_tcur;
	logic sel_order;
	logic sel_tick;
	logic sel_drop;
	logic sel_cmd;
	logic sel_value;
	logic upper;
	logic timer_tick;
	logic [15:0] phase_sum;
	logic [1:0] tick_inc;
	logic [31:0] drop_base;
	logic [31:0] rd_word;

	assign sel_tcfg = host_in.addr[7:2] == OFS_TIMER_CONFIG[7:2];
	assign sel_tcur = host_in.addr[7:2] == OFS_TIMER_CURRENT_VALUE[7:2];
	assign sel_order = host_in.addr[7:2] == OFS_HOST_WORD_ORDER[7:2];
	assign sel_tick = host_in.addr[7:2] == OFS_FREE_RUNNING_TICK_COUNT[7:2];
	assign sel_drop = host_in.addr[7:2] == OFS_LOST_FRAME_COUNTER[7:2];
	assign sel_cmd = host_in.addr[7:2] == OFS_MAC_INDIRECT_COMMAND[7:2];
	assign sel_value = host_in.addr[7:2] == OFS_MAC_INDIRECT_VALUE[7:2];
	// A1 picks the half, inverted when the order register is all ones
	assign upper = host_in.addr[1] ^ s.swap; // RULE7 RULE8
	assign timer_tick = (s.tick_div == TICK_LAST);

	always_comb begin
		n = s;
		n.timer_irq = 1'b0;
		n.drop_irq = 1'b0;
		n.rvalid = 1'b0;
		rd_word = 32'h0000_0000;
		drop_base = s.drop;

		// 2.5 ticks per clock: phase accumulator, no gating by power state
		phase_sum = s.phase + TICK_FREQ_KHZ;
		tick_inc = 2'h0;
		for (int i = 0; i < 3; i++) begin
			if (phase_sum >= CLK_FREQ_KHZ) begin
				phase_sum = phase_sum - CLK_FREQ_KHZ;
				tick_inc = tick_inc + 2'h1;
			end
		end
		n.phase = phase_sum;
		n.tick_count = s.tick_count + {30'h0, tick_inc}; // RULE10 RULE13

		if (timer_tick) begin
			n.tick_div = 16'h0000;
		end else begin
			n.tick_div = s.tick_div + 16'h0001;
		end
		if (s.run && timer_tick) begin // RULE1
			if (s.count == 16'h0000) begin
				n.count = s.preload; // RULE6
				n.timer_irq = 1'b1; // RULE4
			end else begin
				n.count = s.count - 16'h0001; // RULE6
			end
		end

		if (s.busy && mac_ack_in) begin
			n.busy = 1'b0; // RULE18
			if (s.read_not_write) begin
				n.mac_value = mac_rdata_in; // RULE22
			end
		end

		if (host_in.rd) begin
			n.rvalid = 1'b1;
			if (sel_tcfg) begin
				rd_word = {2'b00, s.run, 13'h0000, s.preload};
			end
			if (sel_tcur) begin
				rd_word = {16'h0000, s.count}; // RULE5
			end
			if (sel_order) begin
				rd_word = s.word_order;
			end
			if (sel_tick) begin
				if (s.tick_held) begin
					rd_word = s.tick_snap; // RULE11
					n.tick_held = 1'b0;
				end else begin
					rd_word = s.tick_count;
					n.tick_snap = s.tick_count; // RULE11
					n.tick_held = 1'b1;
				end
			end
			if (sel_drop) begin
				if (s.drop_held) begin
					rd_word = s.drop_snap;
					n.drop_held = 1'b0;
				end else begin
					// Capture and clear together so no drop is lost
					rd_word = s.drop;
					n.drop_snap = s.drop;
					n.drop_held = 1'b1;
					drop_base = DROP_RESET; // RULE15
				end
			end
			if (sel_cmd) begin
				rd_word = {s.busy, s.read_not_write, 22'h00_0000, s.mac_addr};
			end
			if (sel_value) begin
				rd_word = s.mac_value;
			end
			n.rdata = upper ? rd_word[31:16] : rd_word[15:0];
		end

		// An increment in the clearing cycle survives: set wins
		if (frame_dropped_in) begin
			n.drop = drop_base + 32'h0000_0001; // RULE14
			if (drop_base == DROP_BELOW_MID) begin
				n.drop_irq = 1'b1; // RULE16
			end
		end else begin
			n.drop = drop_base;
		end

		if (host_in.wr) begin
			if (sel_tcfg && upper) begin
				n.run = host_in.wdata[RUN_BIT - HALF_WIDTH]; // RULE1
				if (s.run && !host_in.wdata[RUN_BIT - HALF_WIDTH]) begin
					n.preload = PRELOAD_RESET; // RULE2
				end
				if (!s.run && host_in.wdata[RUN_BIT - HALF_WIDTH]) begin
					n.count = s.preload; // RULE3
				end
			end
			if (sel_tcfg && !upper) begin
				n.preload = host_in.wdata; // RULE3
			end
			if (sel_order && upper) begin
				n.word_order[31:16] = host_in.wdata;
			end
			if (sel_order && !upper) begin
				n.word_order[15:0] = host_in.wdata;
			end
			// Writes while busy are dropped to keep the access coherent
			if (sel_cmd && !s.busy) begin // RULE19
				if (upper) begin
					n.busy = host_in.wdata[BUSY_BIT - HALF_WIDTH]; // RULE17
					n.read_not_write =
						host_in.wdata[READ_NOT_WRITE_BIT - HALF_WIDTH]; // RULE20
				end else begin
					n.mac_addr = host_in.wdata[7:0]; // RULE21
				end
			end
			if (sel_value && !s.busy) begin // RULE19
				if (upper) begin
					n.mac_value[31:16] = host_in.wdata; // RULE22
				end else begin
					n.mac_value[15:0] = host_in.wdata; // RULE22
				end
			end
		end
		n.swap = (n.word_order == WORD_ORDER_SWAPPED); // RULE8
	end

	// Counter clears at once, well inside the allowed lag
	always_ff @(posedge clock_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s <= CSR_RESET; // RULE12
		end else begin
			s <= n;
		end
	end

	assign host_rdata_out = s.rdata;
	assign host_rvalid_out = s.rvalid;
	assign word_order_swapped_out = s.swap;
	assign timer_irq_out = s.timer_irq;
	assign drop_half_irq_out = s.drop_irq;
	assign mac_out.req = s.busy;
	assign mac_out.read_not_write = s.read_not_write;
	assign mac_out.addr = s.mac_addr;
	assign mac_out.wdata = s.mac_value;

	net_half_order u_net_half_order (
		.clock_in(clock_in),
		.rst_n_in(rst_n_in),
		.tx_word_in(tx_word_in),
		.tx_word_valid_in(tx_word_valid_in),
		.tx_ready_out(tx_ready_out),
		.net_tx_half_out(net_tx_half_out),
		.net_tx_valid_out(net_tx_valid_out),
		.net_rx_half_in(net_rx_half_in),
		.net_rx_valid_in(net_rx_valid_in),
		.rx_word_out(rx_word_out),
		.rx_word_valid_out(rx_word_valid_out)
	);

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_n_in);

	sequence mac_start_seq;
		host_in.wr && sel_cmd && upper && !s.busy &&
			host_in.wdata[BUSY_BIT - HALF_WIDTH];
	endsequence

	sequence mac_read_done_seq;
		s.busy && s.read_not_write && mac_ack_in;
	endsequence

	chk_timer_halt: assert property ( // RULE1
		(!s.run && !(host_in.wr && sel_tcfg)) |=> $stable(s.count))
		else $error("timer count moved while halted");

	chk_preload_force: assert property ( // RULE2
		$fell(s.run) |-> s.preload == PRELOAD_RESET)
		else $error("preload not forced to ones on halt");

	chk_start_load: assert property ( // RULE3
		$rose(s.run) |-> s.count == $past(s.preload))
		else $error("timer did not start from preload");

	chk_timer_wrap: assert property ( // RULE4
		(s.run && timer_tick && s.count == 16'h0000 &&
			!(host_in.wr && sel_tcfg))
		|=> timer_irq_out && s.count == $past(s.preload))
		else $error("timer wrap without reload or interrupt");

	chk_count_view: assert property ( // RULE5
		(host_in.rd && sel_tcur && !upper) |=> host_rdata_out == $past(s.count))
		else $error("current count read back wrong");

	chk_half_select: assert property ( // RULE7
		(host_in.rd && sel_order && host_in.addr[1] && !s.swap)
		|=> host_rdata_out == $past(s.word_order[31:16]))
		else $error("upper half not selected in normal order");

	chk_tick_rate: assert property ( // RULE10
		$past(rst_n_in) |-> (32'(s.tick_count - $past(s.tick_count))
			inside {32'h0000_0002, 32'h0000_0003}))
		else $error("tick counter rate wrong");

	chk_tick_pair: assert property ( // RULE11
		(host_in.rd && sel_tick && s.tick_held && upper)
		|=> host_rdata_out == $past(s.tick_snap[31:16]))
		else $error("second half not from latched count");

	chk_drop_count: assert property ( // RULE14
		(frame_dropped_in && !(host_in.rd && sel_drop))
		|=> s.drop == $past(s.drop) + 32'h0000_0001)
		else $error("dropped frame not counted");

	chk_drop_clear: assert property ( // RULE15
		(host_in.rd && sel_drop && !s.drop_held && !frame_dropped_in)
		|=> s.drop == DROP_RESET)
		else $error("lost counter not cleared by read");

	chk_drop_mid: assert property ( // RULE16
		(s.drop_irq == (s.drop == DROP_MID && $past(s.drop) == DROP_BELOW_MID)))
		else $error("midpoint interrupt mismatch");

	chk_mac_start: assert property ( // RULE17
		mac_start_seq |=> mac_out.req ##0
			(mac_out.read_not_write ==
			$past(host_in.wdata[READ_NOT_WRITE_BIT - HALF_WIDTH])))
		else $error("indirect access not started");

	chk_busy_hold: assert property ( // RULE18
		(s.busy && !mac_ack_in) |=> s.busy)
		else $error("busy cleared before completion");

	chk_read_done: assert property ( // RULE18
		mac_read_done_seq |=> !s.busy && s.mac_value == $past(mac_rdata_in))
		else $error("read data not valid when busy clears");

endmodule

// >>> test/mac_model.sv
`timescale 1ns/100ps
module mac_model
	import misc_csr_pkg::*;
(
	input wire logic clock_in,
	input wire mac_req_s mac_in,
	input wire logic [3:0] delay_in,
	output logic ack_out,
	output logic [31:0] rdata_out
);
	logic [31:0] regs [256];
	int wait_n;

	initial begin
		ack_out = 1'b0;
		rdata_out = 32'h0000_0000;
		wait_n = 0;
	end

	always @(posedge clock_in) begin
		ack_out <= 1'b0;
		// Data is only meaningful in the ack cycle, so it toggles elsewhere
		rdata_out <= ~rdata_out;
		if (mac_in.req && !ack_out) begin
			if (wait_n < int'(delay_in)) begin
				wait_n <= wait_n + 1;
			end else begin
				wait_n <= 0;
				ack_out <= 1'b1;
				if (mac_in.read_not_write) begin
					rdata_out <= regs[mac_in.addr];
				end else begin
					regs[mac_in.addr] <= mac_in.wdata;
				end
			end
		end
	end
endmodule

// >>> test/testbench.sv
`timescale 1ns/100ps
module testbench;
	import misc_csr_pkg::*;
	localparam int TICKS = 4;
	logic clock_in, rst_n_in, frame_dropped_in, mac_ack_in;
	logic tx_word_valid_in, net_rx_valid_in, host_rvalid_out;
	logic word_order_swapped_out, timer_irq_out, drop_half_irq_out;
	logic tx_ready_out, net_tx_valid_out, rx_word_valid_out;
	logic [15:0] host_rdata_out, net_tx_half_out, net_rx_half_in;
	logic [31:0] mac_rdata_in, tx_word_in, rx_word_out, seed;
	logic [3:0] delay;
	host_bus_s host_in;
	mac_req_s mac_out;
	int num_errors, n_tests, cyc;

	misc_system_csr_block #(.TIMER_TICK_CYCLES(TICKS)) dut_u (
		.clock_in, .rst_n_in, .host_in, .host_rdata_out, .host_rvalid_out,
		.word_order_swapped_out, .timer_irq_out, .frame_dropped_in,
		.drop_half_irq_out, .mac_out, .mac_ack_in, .mac_rdata_in, .tx_word_in,
		.tx_word_valid_in, .tx_ready_out, .net_tx_half_out, .net_tx_valid_out,
		.net_rx_half_in, .net_rx_valid_in, .rx_word_out, .rx_word_valid_out
	);
	mac_model mac_u (.clock_in, .mac_in(mac_out), .delay_in(delay),
		.ack_out(mac_ack_in), .rdata_out(mac_rdata_in));

	initial begin
		clock_in = 1'b0;
		forever #50 clock_in = ~clock_in;
	end
	always @(posedge clock_in) cyc <= cyc + 1;

	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic stop_test();
		$display("checks %0d, errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic step();
		@(posedge clock_in);
		#10;
	endtask

	// Idle cycle after each access keeps strobes from being set twice
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		host_in = '{addr: a, rd: 1'b0, wr: 1'b1, wdata: d};
		step();
		host_in.wr = 1'b0;
		step();
	endtask

	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		host_in = '{addr: a, rd: 1'b1, wr: 1'b0, wdata: 16'h0000};
		step();
		host_in.rd = 1'b0;
		d = host_rvalid_out === 1'b1 ? host_rdata_out : 'x;
		step();
	endtask

	task automatic wait_irq(output int at);
		int k;
		k = 0;
		while (timer_irq_out !== 1'b1 && k < 100) begin
			step();
			k++;
		end
		at = cyc;
		step();
	endtask

	task automatic poll(output int k);
		logic [15:0] v;
		k = 0;
		do begin
			rd(OFS_MAC_INDIRECT_COMMAND | 8'h02, v);
			k++;
		end while (v[15] !== 1'b0 && k < 50);
	endtask

	initial begin
		#(20000 * CLK_PERIOD_NS);
		num_errors++;
		$display("unexpected run length: expected end, seen hang");
		stop_test();
	end

	initial begin
		logic [15:0] v, w, p;
		logic [31:0] x, y, d;
		logic [7:0] a;
		int t, e, t2, k, n;
		host_in = '0;
		frame_dropped_in = 1'b0;
		tx_word_valid_in = 1'b0;
		net_rx_valid_in = 1'b0;
		tx_word_in = 32'h0000_0000;
		net_rx_half_in = 16'h0000;
		delay = 4'h0;
		rst_n_in = 1'b0;
		seed = 32'h0000_b5c8;
		num_errors = 0;
		n_tests = 0;
		cyc = 0;
		repeat (20) @(posedge clock_in);
		#10;
		rst_n_in = 1'b1;
		t = cyc;
		rd(OFS_FREE_RUNNING_TICK_COUNT, v);
		e = cyc - 1;
		rd(OFS_FREE_RUNNING_TICK_COUNT | 8'h02, w);
		x = {w, v} - 32'(5 * (e - t) / 2) + 32'h0000_0004;
		check("tick after reset", 1, 32'(x <= 8));
		rd(OFS_TIMER_CONFIG, v);
		check("preload reset", 32'h0000_ffff, 32'(v));
		rd(OFS_TIMER_CURRENT_VALUE, v);
		check("count reset", 32'h0000_ffff, 32'(v));
		rd(8'h40, v);
		check("unmapped", 32'h0000_0000, 32'(v));
		repeat (37) step();
		rd(OFS_FREE_RUNNING_TICK_COUNT, v);
		x = {16'h0000, v};
		rd(OFS_FREE_RUNNING_TICK_COUNT, w);
		check("tick latch", x, 32'(w));
		rd(OFS_FREE_RUNNING_TICK_COUNT | 8'h02, w);
		t2 = cyc - 1;
		rd(OFS_FREE_RUNNING_TICK_COUNT, v);
		y = {w, v} - 32'(5 * t2 / 2) + 32'(5 * t / 2) + 32'h0000_0004;
		check("tick rate", 1, 32'(y <= 8));

		k = int'(xs() % 20) + 1;
		n = 0;
		while (n < k) begin
			x = xs();
			frame_dropped_in = x[0];
			n += int'(x[0]);
			step();
		end
		frame_dropped_in = 1'b0;
		step();
		check("drop irq", 0, 32'(drop_half_irq_out));
		rd(OFS_LOST_FRAME_COUNTER, v);
		rd(OFS_LOST_FRAME_COUNTER | 8'h02, w);
		check("lost count", 32'(k), {w, v});
		rd(OFS_LOST_FRAME_COUNTER, v);
		check("lost cleared", 32'h0000_0000, 32'(v));

		p = 16'(xs() % 6 + 1);
		wr(OFS_TIMER_CONFIG, p);
		wr(OFS_TIMER_CONFIG | 8'h02, 16'h2000);
		rd(OFS_TIMER_CURRENT_VALUE, v);
		check("start count", 1, 32'(v == p || v == p - 1));
		wait_irq(t);
		wait_irq(t2);
		check("timer period", 32'((p + 1) * TICKS), 32'(t2 - t));
		wr(OFS_TIMER_CONFIG | 8'h02, 16'h0000);
		rd(OFS_TIMER_CONFIG, v);
		check("preload preset", 32'h0000_ffff, 32'(v));
		rd(OFS_TIMER_CURRENT_VALUE, v);
		repeat (3 * TICKS) step();
		rd(OFS_TIMER_CURRENT_VALUE, w);
		check("halted count", 32'(v), 32'(w));

		wr(OFS_HOST_WORD_ORDER, 16'hffff);
		wr(OFS_HOST_WORD_ORDER | 8'h02, 16'hffff);
		check("swapped", 1, 32'(word_order_swapped_out));
		x = xs();
		p = x[15:0];
		wr(OFS_TIMER_CONFIG | 8'h02, p);
		rd(OFS_TIMER_CONFIG, v);
		check("swapped upper", 32'h0000_0000, 32'(v));
		repeat (3) begin
			x = xs();
			y = xs();
			tx_word_in = x;
			tx_word_valid_in = 1'b1;
			net_rx_half_in = y[15:0];
			net_rx_valid_in = 1'b1;
			check("tx ready", 1, 32'(tx_ready_out));
			step();
			check("tx taken", 0, 32'(tx_ready_out));
			tx_word_valid_in = 1'b0;
			net_rx_half_in = y[31:16];
			d = net_tx_valid_out === 1'b1 ? 32'(net_tx_half_out) : 'x;
			check("tx low", 32'(x[15:0]), d);
			step();
			net_rx_valid_in = 1'b0;
			net_rx_half_in = ~y[31:16];
			tx_word_in = ~x;
			d = net_tx_valid_out === 1'b1 ? 32'(net_tx_half_out) : 'x;
			check("tx high", 32'(x[31:16]), d);
			d = rx_word_valid_out === 1'b1 ? rx_word_out : 'x;
			check("rx word", y, d);
			repeat (3) step();
		end
		wr(OFS_HOST_WORD_ORDER, 16'h0000);
		check("not swapped", 0, 32'(word_order_swapped_out));
		rd(OFS_HOST_WORD_ORDER | 8'h02, v);
		check("order upper", 32'h0000_0000, 32'(v));
		rd(OFS_HOST_WORD_ORDER, v);
		check("order lower", 32'h0000_ffff, 32'(v));
		rd(OFS_TIMER_CONFIG, v);
		check("plain lower", 32'(p), 32'(v));

		for (int i = 0; i < 4; i++) begin
			delay = 4'(i * 3);
			x = xs();
			a = x[7:0];
			d = xs();
			wr(OFS_MAC_INDIRECT_VALUE, d[15:0]);
			wr(OFS_MAC_INDIRECT_VALUE | 8'h02, d[31:16]);
			wr(OFS_MAC_INDIRECT_COMMAND, 16'(a));
			wr(OFS_MAC_INDIRECT_COMMAND | 8'h02, 16'h8000);
			poll(k);
			check("mac write", d, mac_u.regs[a]);
			wr(OFS_MAC_INDIRECT_COMMAND | 8'h02, 16'hc000);
			poll(k);
			check("busy span", 1, 32'(k > 1 || i == 0));
			rd(OFS_MAC_INDIRECT_VALUE, v);
			rd(OFS_MAC_INDIRECT_VALUE | 8'h02, w);
			check("mac read", d, {w, v});
		end
		stop_test();
	end
endmodule
